// ==== rtl/srw_supervisor.sv ====
// Supervisor reset watchdog: reset pulse generator, watchdog, supply
// switchover control and power-fail flag.
// Assumes comparator and watchdog inputs come from pins and are synchronised here; reset_n is used unsynchronised.
//
// Summary of operation
// - Reset pulse on power-up, power-down and watchdog expiry.
// - Pulse lasts 200 ms; polarity set by build parameter.
// - Rising supply past threshold holds reset one full pulse time.
// - Supply below threshold asserts reset, held down to 1.1 V.
// - Watchdog input unchanged beyond 1.6 s timeout causes reset.
// - After a pulse a fresh interval starts; edge or float restarts it.
// - Held watchdog input repeats resets every timeout plus pulse width.
// - A 50 ns level change still counts as service.
// - Switch to backup only when main below threshold and below backup.
// - Return to main as soon as main exceeds threshold.
// - Threshold is a build option, 4.65 V or 4.4 V.
// - In backup mode reset asserted, power-fail low, watchdog off.
// - Main 1.1 V below backup freezes comparator outputs in backup state.
// - Power-fail output low when sense input below 1.25 V reference.
`timescale 1ns/1ps
module srw_supervisor
  import srw_pkg::*;
#(
  parameter logic RESET_ACTIVE_HIGH = RESET_ACTIVE_HIGH_DEFAULT,
  parameter logic THRESHOLD_LOW_OPTION = 1'b0,
  parameter int TICK_DIV = TICK_CYCLES,
  parameter int PULSE_TICKS = RESET_PULSE_TICKS,
  parameter int TIMEOUT_TICKS = WATCHDOG_TIMEOUT_TICKS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire srw_cmp_t cmpIn,
  input wire srw_wdi_t watchdogServiceInput,
  output logic processorReset,
  output logic powerFailFlagOutput,
  output logic backupPathSwitches,
  output logic mainPathSwitches,
  output logic thresholdSelect
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Two stages for every pin flag; only the second stage is read.
  srw_cmp_t cmpS1Reg, cmpS2Reg;
  srw_wdi_t wdiS1Reg, wdiS2Reg, wdiPrevReg;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmpS1Reg <= CMP_SYNC_RESET;
      cmpS2Reg <= CMP_SYNC_RESET;
      wdiS1Reg <= '0;
      wdiS2Reg <= '0;
      wdiPrevReg <= '0;
    end else begin
      cmpS1Reg <= cmpIn;
      cmpS2Reg <= cmpS1Reg;
      wdiS1Reg <= watchdogServiceInput;
      wdiS2Reg <= wdiS1Reg;
      wdiPrevReg <= wdiS2Reg;
    end
  end

  // A short pulse is only caught if it spans a clock edge; at 8 ns per
  // cycle a 50 ns pulse spans several, so no separate latch is needed.
  logic serviceEvent;
  assign serviceEvent = (wdiS2Reg.level != wdiPrevReg.level) || wdiS2Reg.floating;

  // ----------------------------------------------------------------
  // Backup mode and frozen comparators
  // ----------------------------------------------------------------
  logic backupReg, backupNext, frozenReg, frozenNext;
  logic pfoReg, pfoNext;
  logic mainReg, mainNext;
  always_comb begin
    frozenNext = backupReg && cmpS2Reg.mainFarBelowBackup;
    backupNext = backupReg;
    pfoNext = pfoReg;
    if (cmpS2Reg.mainAboveThreshold) begin
      backupNext = 1'b0;
    end else if (!frozenReg && !cmpS2Reg.mainAboveBackup) begin
      backupNext = 1'b1;
    end
    if (backupNext) begin
      pfoNext = 1'b0;
    end else begin
      pfoNext = cmpS2Reg.powerFailAboveRef;
    end
    // The main path is the complement, kept in its own flop so the pin is registered.
    mainNext = !backupNext;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      backupReg <= 1'b0;
      frozenReg <= 1'b0;
      pfoReg <= 1'b0;
      mainReg <= 1'b1;
    end else begin
      backupReg <= backupNext;
      frozenReg <= frozenNext;
      pfoReg <= pfoNext;
      mainReg <= mainNext;
    end
  end

  // ----------------------------------------------------------------
  // Timebase and reset/watchdog state machine
  // ----------------------------------------------------------------
  // One free-running divider keeps long counts narrow.
  logic [TICK_W-1:0] divReg, divNext;
  logic tick;
  assign tick = (divReg == TICK_W'(TICK_DIV - 1));
  always_comb begin
    divNext = tick ? '0 : divReg + 1'b1;
  end

  srw_state_t stateReg, stateNext;
  logic [COUNT_W-1:0] cntReg, cntNext;
  logic rstReg, rstNext;
  always_comb begin
    stateNext = stateReg;
    cntNext = cntReg;
    unique case (stateReg)
      SRW_POWER_DOWN: begin
        cntNext = '0;
        if (cmpS2Reg.mainAboveThreshold) begin
          stateNext = SRW_RESET_PULSE;
        end
      end
      SRW_RESET_PULSE: begin
        if (tick) begin
          cntNext = cntReg + 1'b1;
        end
        if (tick && cntReg == COUNT_W'(PULSE_TICKS - 1)) begin
          stateNext = SRW_RUN;
          cntNext = '0;
        end
      end
      SRW_RUN: begin
        if (serviceEvent) begin
          cntNext = '0;
        end else if (tick) begin
          cntNext = cntReg + 1'b1;
        end
        if (!serviceEvent && tick && cntReg == COUNT_W'(TIMEOUT_TICKS - 1)) begin
          stateNext = SRW_RESET_PULSE;
          cntNext = '0;
        end
      end
      default: begin
        stateNext = SRW_POWER_DOWN;
        cntNext = '0;
      end
    endcase
    // Low supply or backup mode overrides everything and stops the watchdog.
    if (!cmpS2Reg.mainAboveThreshold || backupNext) begin
      stateNext = SRW_POWER_DOWN;
      cntNext = '0;
    end
    rstNext = (stateNext != SRW_RUN) ^ RESET_ACTIVE_HIGH ? 1'b0 : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      divReg <= '0;
      stateReg <= SRW_POWER_DOWN;
      cntReg <= '0;
      rstReg <= RESET_ACTIVE_HIGH; // Processor reset is held asserted while the block is in reset.
    end else begin
      divReg <= divNext;
      stateReg <= stateNext;
      cntReg <= cntNext;
      rstReg <= rstNext;
    end
  end

  // Threshold option is fixed per build and exported for the comparator.
  logic thrReg;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      thrReg <= 1'b0;
    end else begin
      thrReg <= THRESHOLD_LOW_OPTION;
    end
  end

  assign processorReset = rstReg;
  assign powerFailFlagOutput = pfoReg;
  assign backupPathSwitches = backupReg;
  assign mainPathSwitches = mainReg;
  assign thresholdSelect = thrReg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic resetActive;
  assign resetActive = (rstReg == RESET_ACTIVE_HIGH);

  sequence lowSupply_s;
    !cmpS2Reg.mainAboveThreshold;
  endsequence

  brownoutReset_a: assert property (@(posedge clk) disable iff (!reset_n)
    lowSupply_s |=> resetActive) else $error("reset not asserted on low supply");
  backupSwitch_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!frozenReg && !cmpS2Reg.mainAboveThreshold && !cmpS2Reg.mainAboveBackup) |=> backupReg)
    else $error("no switch to backup");
  returnMain_a: assert property (@(posedge clk) disable iff (!reset_n)
    cmpS2Reg.mainAboveThreshold |=> !backupReg) else $error("no return to main");
  backupPfo_a: assert property (@(posedge clk) disable iff (!reset_n)
    backupReg |-> (!pfoReg && resetActive)) else $error("backup mode outputs wrong");
  powerFail_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!backupNext) |=> (pfoReg == $past(cmpS2Reg.powerFailAboveRef))) else $error("power-fail flag wrong");
  freezeHold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (frozenReg && !cmpS2Reg.mainAboveThreshold) |=> backupReg) else $error("frozen state left backup");
  serviceRestart_a: assert property (@(posedge clk) disable iff (!reset_n)
    (stateReg == SRW_RUN && serviceEvent && cmpS2Reg.mainAboveThreshold && !backupNext) |=> (cntReg == '0))
    else $error("service did not restart interval");
  pulseEnd_a: assert property (@(posedge clk) disable iff (!reset_n)
    (stateReg == SRW_RESET_PULSE && stateNext == SRW_RUN) |-> (tick && cntReg == COUNT_W'(PULSE_TICKS - 1)))
    else $error("pulse ended early");
  timeout_a: assert property (@(posedge clk) disable iff (!reset_n)
    (stateReg == SRW_RUN && stateNext == SRW_RESET_PULSE) |-> (cntReg == COUNT_W'(TIMEOUT_TICKS - 1)))
    else $error("watchdog expired at wrong count");

endmodule : srw_supervisor

// ==== rtl/srw_pkg.sv ====
// Package for the supervisor reset watchdog block.
// Assumes a 125 MHz system clock; analog comparators arrive as digital flags.
package srw_pkg;

  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 64'd125000000;
  localparam int RESET_PULSE_TIME_MS = 200;
  localparam int WATCHDOG_TIMEOUT_TIME_MS = 1600;
  localparam int SERVICE_PULSE_MIN_WIDTH_NS = 50;
  // Timebase tick of 1 ms; the intervals count ticks.
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = int'((CLK_HZ * TICK_US) / 64'd1000000);
  localparam int RESET_PULSE_TICKS = RESET_PULSE_TIME_MS * 1000 / TICK_US;
  localparam int WATCHDOG_TIMEOUT_TICKS = WATCHDOG_TIMEOUT_TIME_MS * 1000 / TICK_US;
  localparam int TICK_W = 17;
  localparam int COUNT_W = 12;

  // ----------------------------------------------------------------
  // Reset values and states
  // ----------------------------------------------------------------
  localparam logic RESET_ACTIVE_HIGH_DEFAULT = 1'b0;
  localparam logic [1:0] SYNC_RESET_VALUE = 2'h0;

  typedef enum logic [1:0] {
    SRW_POWER_DOWN = 2'h0,
    SRW_RESET_PULSE = 2'h1,
    SRW_RUN = 2'h3
  } srw_state_t;

  // Comparator flags from the analog front end.
  typedef struct packed {
    logic mainAboveThreshold;
    logic mainAboveBackup;
    logic mainFarBelowBackup;
    logic powerFailAboveRef;
    logic mainAboveMinimum;
  } srw_cmp_t;

  // Comparator synchroniser value after reset: supply low but above backup.
  // This keeps reset asserted without a false switch to the backup supply.
  localparam srw_cmp_t CMP_SYNC_RESET = 5'h08;

  // Watchdog service input seen as a level plus a float detect.
  typedef struct packed {
    logic level;
    logic floating;
  } srw_wdi_t;

endpackage : srw_pkg

// ==== verification/srw_processor_model.sv ====
// Processor model: receives the reset and drives the watchdog service input.
// Assumes the bench picks its mode: 0 toggles, 1 holds the level, 2 floats the pin.
`timescale 1ns/1ps
module srw_processor_model
  import srw_pkg::*;
(
  input wire logic clk,
  input wire logic processorReset,
  input wire logic [1:0] mode,
  output srw_wdi_t watchdog_service_input
);
  // ----------------------------------------------------------------
  // Service behaviour
  // ----------------------------------------------------------------
  int cnt = 0;
  logic lvl = 1'b0;
  initial watchdog_service_input = 2'h0;
  // Toggles every 60 cycles out of reset, well inside the shortened timeout.
  // A floating pin shows a level that changes every cycle, never a held value.
  always @(posedge clk) begin
    cnt <= (cnt == 59) ? 0 : cnt + 1;
    if (mode == 2'h0 && processorReset === 1'b1 && cnt == 59) lvl <= ~lvl;
    watchdog_service_input.level <= (mode == 2'h2) ? ~watchdog_service_input.level : lvl;
    watchdog_service_input.floating <= (mode == 2'h2);
  end
endmodule : srw_processor_model

// ==== verification/test_supervisor_reset_watchdog.sv ====
// Testbench for the supervisor reset watchdog with a processor model.
// Assumes shortened timing: 10-cycle tick, 4-tick pulse, 16-tick timeout.
`timescale 1ns/1ps
module test_supervisor_reset_watchdog
  import srw_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int DIV = 10;
  localparam int PUL = 4;
  localparam int TMO = 16;
  localparam int PULSE = DIV * PUL;
  localparam int IDLE = DIV * TMO;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  srw_cmp_t cmp = 5'h0B;
  logic [1:0] mode = 2'h0;
  srw_wdi_t watchdog_service_input;
  logic rstOut;
  logic power_fail_flag_output;
  logic bak;
  logic mainSw;
  logic thr;
  int failures = 0;
  int compares = 0;
  int ticks = 0;
  int n;
  srw_supervisor #(.TICK_DIV(DIV), .PULSE_TICKS(PUL), .TIMEOUT_TICKS(TMO)) uut (.clk(clk), .reset_n(reset_n),
    .cmpIn(cmp), .watchdogServiceInput(watchdog_service_input), .processorReset(rstOut), .powerFailFlagOutput(power_fail_flag_output),
    .backupPathSwitches(bak), .mainPathSwitches(mainSw), .thresholdSelect(thr));
  srw_processor_model cpu (.clk(clk), .processorReset(rstOut), .mode(mode), .watchdog_service_input(watchdog_service_input));
  // Clock and a hang guard well above the expected run length.
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 6000) begin
      failures++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk
  // Waits for the reset output to reach a level; k counts the cycles taken.
  task automatic wait_rst(input logic v, input int lim, output int k);
    k = 0;
    while (rstOut !== v && k < lim) begin
      tick(1);
      k++;
    end
  endtask : wait_rst
  task automatic quiet(input int len, input string what);
    int lows;
    lows = 0;
    repeat (len) begin
      tick(1);
      if (rstOut !== 1'b1) lows++;
    end
    chk(lows == 0, 1'b1, what);
  endtask : quiet
  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Power-up: no backup switch while above backup, then one full pulse.
  task automatic test_power_up();
    chk(thr, 1'b0, "threshold option");
    chk(bak, 1'b0, "no backup while above backup");
    chk(mainSw, 1'b1, "main path after reset");
    @(posedge clk) cmp.mainAboveThreshold <= 1'b1;
    tick(20);
    chk(rstOut, 1'b0, "reset held after power-up");
    wait_rst(1'b1, 2 * PULSE, n);
    chk(n + 20 >= PULSE - DIV && n + 20 <= PULSE + DIV, 1'b1, "power-up pulse width");
    quiet(400, "reset while serviced");
    $display("test power_up done");
  endtask : test_power_up
  // A floating pin counts as service on every cycle.
  task automatic test_floating();
    @(posedge clk) mode <= 2'h2;
    quiet(400, "reset while floating");
    $display("test floating done");
  endtask : test_floating
  // Held level: expiry, pulse width, repeat interval, then service again.
  task automatic test_held_input();
    @(posedge clk) mode <= 2'h1;
    wait_rst(1'b0, IDLE + 2 * DIV, n);
    chk(rstOut, 1'b0, "watchdog expiry");
    wait_rst(1'b1, 2 * PULSE, n);
    chk(n >= PULSE - DIV && n <= PULSE + DIV, 1'b1, "watchdog pulse width");
    wait_rst(1'b0, 2 * IDLE, n);
    chk(n >= IDLE - DIV && n <= IDLE + DIV, 1'b1, "repeat period");
    @(posedge clk) mode <= 2'h0;
    wait_rst(1'b1, 2 * PULSE, n);
    chk(rstOut, 1'b1, "pulse released after service resumes");
    $display("test held_input done");
  endtask : test_held_input
  // The power-fail flag follows the sense comparator.
  task automatic test_power_fail();
    @(posedge clk) cmp.powerFailAboveRef <= 1'b0;
    tick(4);
    chk(power_fail_flag_output, 1'b0, "flag low below reference");
    @(posedge clk) cmp.powerFailAboveRef <= 1'b1;
    tick(4);
    chk(power_fail_flag_output, 1'b1, "flag high above reference");
    $display("test power_fail done");
  endtask : test_power_fail
  // Brown-out, switch to backup, frozen comparators, then recovery.
  task automatic test_backup();
    @(posedge clk) cmp.mainAboveThreshold <= 1'b0;
    tick(4);
    chk(rstOut, 1'b0, "brown-out reset");
    chk(bak, 1'b0, "stay on main above backup");
    @(posedge clk) cmp.mainAboveBackup <= 1'b0;
    tick(4);
    chk(bak, 1'b1, "switch to backup");
    chk(mainSw, 1'b0, "main path open");
    chk(power_fail_flag_output, 1'b0, "flag low in backup");
    tick(300);
    chk(rstOut, 1'b0, "reset kept in backup");
    @(posedge clk) cmp.mainFarBelowBackup <= 1'b1;
    tick(4);
    chk(bak, 1'b1, "frozen keeps backup");
    chk(power_fail_flag_output, 1'b0, "frozen flag low");
    chk(rstOut, 1'b0, "frozen reset kept");
    @(posedge clk) cmp.mainFarBelowBackup <= 1'b0;
    @(posedge clk) cmp.mainAboveThreshold <= 1'b1;
    tick(4);
    chk(bak, 1'b0, "return to main");
    chk(mainSw, 1'b1, "main path closed");
    wait_rst(1'b1, 2 * PULSE, n);
    chk(n >= PULSE - 2 * DIV && n <= PULSE + DIV, 1'b1, "recovery pulse");
    $display("test backup done");
  endtask : test_backup
  // Reset is sampled low at two edges, then the scenarios run in turn.
  initial begin
    tick(1);
    @(posedge clk) reset_n <= 1'b1;
    tick(2);
    test_power_up();
    test_floating();
    test_held_input();
    test_power_fail();
    test_backup();
    wrap_up();
  end
endmodule : test_supervisor_reset_watchdog
